// *** shared/eeprom_host_pkg.sv ***
// How it works
// - Every byte of one page load carries the same page number.
// - Output enable stays high while strobe and select are both low.
// - After the command sequence one to 128 bytes may be loaded.
// - The command writes (three to lock, six to unlock) use the fixed low fifteen address bits.
// - Next byte is latched within 150 us of the previous one.
// - Completion is seen when the toggle line stops changing or when the program time runs out.
// - Polling reads keep one constant address.
// - Lock is set by three and cleared by six command writes, none of them stored.
`default_nettype none
package eeprom_host_pkg;
	// ==========================================================
	// Pin timing and figures
	localparam int CLK_MHZ = 100;
	localparam int PULSE_NS = 100;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_NS = 150;
	localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int BYTE_WINDOW_US = 150;
	localparam int BYTE_WINDOW_CYC = BYTE_WINDOW_US * CLK_MHZ;
	localparam int PROGRAM_MS = 10;
	localparam int PROGRAM_CYC = PROGRAM_MS * 1000 * CLK_MHZ;
	localparam int READ_NS = 250;
	localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
	localparam int PAGE_BYTES = 128;
	localparam int PAGE_LSB = 7;
	localparam int ADDR_W = 17;
	// Command sequence addresses and data
	localparam logic [14:0] CMD_ADDR0 = 15'h5555;
	localparam logic [14:0] CMD_ADDR1 = 15'h2aaa;
	localparam logic [7:0] CMD_DATA0 = 8'haa;
	localparam logic [7:0] CMD_DATA1 = 8'h55;
	localparam logic [7:0] CMD_LOCK = 8'ha0;
	localparam logic [7:0] CMD_UNLOCK_A = 8'h80;
	localparam logic [7:0] CMD_UNLOCK_B = 8'h20;
	localparam int INV_BIT = 7;
	localparam int TOG_BIT = 6;
	// ==========================================================
	// Request kinds
	typedef enum logic [1:0] {
		OP_WRITE,
		OP_LOCK,
		OP_UNLOCK,
		OP_READ
	} op_e;
	typedef struct packed {
		op_e op;
		logic [ADDR_W-1:0] addr;
		logic [6:0] count;
	} req_s;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
	} bus_s;
endpackage
`default_nettype wire

// *** logic/page_buffer.sv ***
`default_nettype none
module page_buffer #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [DEPTH];
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// *** logic/eeprom_host.sv ***
`default_nettype none
module eeprom_host
	import eeprom_host_pkg::*;
#(
	parameter int WINDOW_CYC = BYTE_WINDOW_CYC,
	parameter int PROG_CYC = PROGRAM_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	// User side: page image loaded first, then a request
	input wire logic fill_valid,
	input wire logic [6:0] fill_index,
	input wire logic [7:0] fill_data,
	input wire logic req_valid,
	output logic req_ready,
	input wire eeprom_host_pkg::req_s req,
	output logic done,
	output logic [7:0] rd_data,
	output logic timeout,
	// Device pins
	output eeprom_host_pkg::bus_s bus,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic [7:0] dq_in
);
	import eeprom_host_pkg::*;

	// ==========================================================
	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_SETUP, S_PULSE, S_GAP, S_NEXT, S_RSET, S_RWAIT,
		S_RCAP, S_POLL, S_DONE
	} state_e;

	state_e state_r, state_nxt;
	req_s req_r;
	bus_s bus_r;
	logic [7:0] dq_r;
	logic dq_oe_r;
	logic [2:0] step_r;
	logic [7:0] idx_r;
	logic [31:0] cnt_r;
	logic [31:0] age_r;
	logic [7:0] s1_r, s2_r;
	logic [7:0] last_r;
	logic have_last_r;
	logic [7:0] rd_r;
	logic done_r, timeout_r;
	logic [7:0] pb_data;
	logic [6:0] buf_rd_a;

	page_buffer #(.DEPTH(PAGE_BYTES), .AW(7)) u_buf (
		.clk_sys(clk_sys),
		.wr_en(fill_valid),
		.wr_addr(fill_index),
		.wr_data(fill_data),
		.rd_addr(buf_rd_a),
		.rd_data(pb_data)
	);

	// ==========================================================
	// Command table and byte selection
	wire is_read = req_r.op == OP_READ;
	wire is_lock = req_r.op == OP_LOCK;
	wire is_unlk = req_r.op == OP_UNLOCK;
	wire [2:0] cmd_len = is_unlk ? 3'd6 : (is_lock ? 3'd3 : 3'd0);
	wire in_cmd = step_r < cmd_len;
	wire [14:0] cmd_a = (step_r == 3'd1 || step_r == 3'd4) ?
		CMD_ADDR1 : CMD_ADDR0;
	wire [7:0] cmd_d =
		(step_r == 3'd0 || step_r == 3'd3) ? CMD_DATA0 :
		(step_r == 3'd1 || step_r == 3'd4) ? CMD_DATA1 :
		(step_r == 3'd2) ? (is_unlk ? CMD_UNLOCK_A : CMD_LOCK) :
		CMD_UNLOCK_B;
	// Page bits fixed from the request, only the byte offset walks
	wire [ADDR_W-1:0] page_a = {req_r.addr[ADDR_W-1:PAGE_LSB],
		7'(req_r.addr[6:0] + idx_r[6:0])};
	wire [ADDR_W-1:0] cmd_full = {2'b00, cmd_a};
	// Lock and unlock follow their sequence with the data page too
	wire [7:0] total = 8'(req_r.count) + 8'd1;
	wire more = in_cmd || (idx_r + 8'd1 < total);
	// Buffer read is registered, so it is addressed one step ahead
	assign buf_rd_a = (state_r == S_IDLE) ? 7'h00 :
		(state_r == S_NEXT && !in_cmd) ? 7'(idx_r + 8'h01) :
		idx_r[6:0];
	// Toggle line compared between two successive captures
	wire sample_fix = rd_r[TOG_BIT] == last_r[TOG_BIT];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: if (req_valid) state_nxt = S_SETUP;
			S_SETUP: state_nxt = S_PULSE;
			S_PULSE: if (cnt_r == 32'(PULSE_CYC - 1)) state_nxt = S_GAP;
			S_GAP: if (cnt_r == 32'(GAP_CYC - 1))
				state_nxt = more ? S_NEXT : S_RSET;
			S_NEXT: state_nxt = S_SETUP;
			S_RSET: if (cnt_r == 32'(GAP_CYC - 1)) state_nxt = S_RWAIT;
			S_RWAIT: if (cnt_r == 32'(READ_CYC + 1)) state_nxt = S_RCAP;
			S_RCAP: state_nxt = is_read ? S_DONE : S_POLL;
			S_POLL: state_nxt = (sample_fix && have_last_r) ||
				age_r >= 32'(PROG_CYC) ? S_DONE : S_RSET;
			S_DONE: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
		if (is_read && state_r == S_SETUP) state_nxt = S_RSET;
	end

	// ==========================================================
	// Pin drive: output enable held high in every write phase
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= S_IDLE;
			req_r <= '0;
			bus_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
			dq_r <= 8'h00;
			dq_oe_r <= 1'b0;
			step_r <= 3'd0;
			idx_r <= 8'h00;
			cnt_r <= 32'h0;
			age_r <= 32'h0;
			s1_r <= 8'h00;
			s2_r <= 8'h00;
			last_r <= 8'h00;
			have_last_r <= 1'b0;
			rd_r <= 8'h00;
			done_r <= 1'b0;
			timeout_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			s1_r <= dq_in;
			s2_r <= s1_r;
			done_r <= state_nxt == S_DONE;
			cnt_r <= state_nxt == state_r ? cnt_r + 32'h1 : 32'h0;
			if (state_r != S_IDLE) age_r <= age_r + 32'h1;
			case (state_r)
				S_IDLE: if (req_valid) begin
					req_r <= req;
					step_r <= 3'd0;
					idx_r <= 8'h00;
					age_r <= 32'h0;
					timeout_r <= 1'b0;
					have_last_r <= 1'b0;
				end
				S_SETUP: if (!is_read) begin
					bus_r.addr <= in_cmd ? cmd_full : page_a;
					dq_r <= in_cmd ? cmd_d : pb_data;
					dq_oe_r <= 1'b1;
					bus_r.oe_n <= 1'b1;
					bus_r.ce_n <= 1'b0;
					bus_r.we_n <= 1'b0;
				end else begin
					bus_r.addr <= req_r.addr;
				end
				S_PULSE: if (cnt_r == 32'(PULSE_CYC - 1)) begin
					bus_r.we_n <= 1'b1;
					bus_r.ce_n <= 1'b1;
				end
				S_GAP: if (cnt_r == 32'(GAP_CYC - 1)) begin
					dq_oe_r <= 1'b0;
					age_r <= 32'h0;
				end
				// Bytes go out far inside the load window
				S_NEXT: begin
					if (in_cmd) step_r <= step_r + 3'd1;
					else idx_r <= idx_r + 8'd1;
				end
				// Poll address is the last byte and never moves
				// Select and output enable rest high before each read
				S_RSET: if (cnt_r == 32'(GAP_CYC - 1)) begin
					if (!is_read) bus_r.addr <= page_a;
					bus_r.ce_n <= 1'b0;
					bus_r.oe_n <= 1'b0;
				end
				S_RCAP: begin
					bus_r.ce_n <= 1'b1;
					bus_r.oe_n <= 1'b1;
					rd_r <= s2_r;
					last_r <= rd_r;
				end
				S_POLL: begin
					have_last_r <= 1'b1;
					if (age_r >= 32'(PROG_CYC)) timeout_r <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	assign req_ready = state_r == S_IDLE;
	assign bus = bus_r;
	assign dq_out = dq_r;
	assign dq_oe = dq_oe_r;
	assign done = done_r;
	assign rd_data = rd_r;
	assign timeout = timeout_r;
endmodule
`default_nettype wire

// *** tb/eeprom_host_assertions.sv ***
`default_nettype none
module eeprom_host_assertions
	import eeprom_host_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic done,
	input wire eeprom_host_pkg::bus_s bus,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic wr = !bus.we_n && !bus.ce_n;
	a_oe_in_write: assert property (wr |-> bus.oe_n)
		else $error("oe low in write");
	a_drive_no_read: assert property (dq_oe |-> bus.oe_n)
		else $error("dq driven in read");
	a_pulse_hold: assert property ($rose(wr) |-> wr[*8])
		else $error("strobe too short");
	a_write_steady: assert property (wr && $past(wr) |->
		$stable(bus.addr) && $stable(dq_out))
		else $error("write changed in strobe");
	a_poll_addr: assert property (!bus.oe_n && $past(!bus.oe_n) |->
		$stable(bus.addr))
		else $error("read addr moved");
	a_next_byte: assert property ($fell(wr) |->
		##[1:1000] ($rose(wr) || !bus.oe_n))
		else $error("byte gap too long");
	a_read_recover: assert property ($rose(bus.oe_n) |-> bus.oe_n[*8])
		else $error("oe high pulse too short");
	a_done_pulse: assert property (done |=> !done)
		else $error("done too long");
	a_taken_busy: assert property (req_valid && req_ready |=> !req_ready)
		else $error("ready after take");
	c_write: cover property ($rose(wr));
	c_read: cover property ($fell(bus.oe_n));
	c_done: cover property (done);
endmodule
bind eeprom_host eeprom_host_assertions u_chk (.clk_sys(clk_sys),
	.rst(rst), .req_valid(req_valid), .req_ready(req_ready),
	.done(done), .bus(bus), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// *** tb/eeprom_model.sv ***
`default_nettype none
module eeprom_model
	import eeprom_host_pkg::*;
#(
	parameter int WIN = 30,
	parameter int PROG = 300
) (
	input wire logic clk_sys,
	input wire eeprom_host_pkg::bus_s bus,
	input wire logic [7:0] dq_out,
	output logic [7:0] dq_in,
	output logic locked
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	logic [16:0] qa [$];
	logic [7:0] qd [$];
	logic [16:0] wa, la;
	logic [7:0] wd, cur;
	logic we_q = 1, rd_q = 0, tog = 0, lk = 0;
	int win = 0, busy = 0;
	wire logic rd = !bus.ce_n && !bus.oe_n;
	initial locked = 0;
	initial dq_in = 0;
	task automatic commit();
		int s;
		logic ok;
		s = 0;
		ok = !locked;
		lk = locked;
		if (qa.size() > 2 && qd[0] == CMD_DATA0 && qd[1] == CMD_DATA1) begin
			if (qd[2] == CMD_LOCK) {s, ok, lk} = {32'd3, 2'b11};
			if (qa.size() > 5 && qd[5] == CMD_UNLOCK_B)
				{s, ok, lk} = {32'd6, 2'b10};
		end
		for (int i = s; i < qa.size(); i++)
			if (ok) mem[qa[i]] = qd[i];
		busy <= PROG;
		qa.delete();
		qd.delete();
	endtask
	always @(posedge clk_sys) begin
		cur = mem.exists(busy > 0 ? la : bus.addr) ?
			mem[busy > 0 ? la : bus.addr] : 8'hff;
		we_q <= bus.we_n | bus.ce_n;
		rd_q <= rd;
		if (rd && !rd_q && busy > 0) tog <= !tog;
		if (!(bus.we_n | bus.ce_n)) {wa, wd} <= {bus.addr, dq_out};
		if (!we_q && (bus.we_n | bus.ce_n)) begin
			qa.push_back(wa);
			qd.push_back(wd);
			la <= wa;
			win <= 0;
		end else if (qa.size() > 0) begin
			win <= win + 1;
			if (win == WIN) commit();
		end
		if (busy > 0) busy <= busy - 1;
		if (busy == 1) locked <= lk;
		if (rd) dq_in <= busy > 0 ? {~cur[7], tog, cur[5:0]} : cur;
		else dq_in <= ~dq_in;
	end
endmodule
`default_nettype wire

// *** tb/eeprom_host_test.sv ***
`default_nettype none
module eeprom_host_test;
	timeunit 1ns;
	timeprecision 1ns;
	import eeprom_host_pkg::*;
	logic clk_sys = 0, rst = 1, fill_valid = 0, req_valid = 0;
	logic [6:0] fill_index = 0;
	logic [7:0] fill_data = 0, rd_data, dq_out, dq_in;
	logic req_ready, done, timeout, dq_oe, locked;
	req_s req = '0;
	bus_s bus;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	eeprom_host #(.WINDOW_CYC(40), .PROG_CYC(2000)) u_eeprom_host (
		.clk_sys(clk_sys), .rst(rst), .fill_valid(fill_valid),
		.fill_index(fill_index), .fill_data(fill_data),
		.req_valid(req_valid), .req_ready(req_ready), .req(req),
		.done(done), .rd_data(rd_data), .timeout(timeout), .bus(bus),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	eeprom_model u_eeprom_model (.clk_sys(clk_sys), .bus(bus),
		.dq_out(dq_out), .dq_in(dq_in), .locked(locked));
	initial forever #5 clk_sys = !clk_sys;
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic fill(logic [7:0] b, int c);
		for (int i = 0; i < c; i++) begin
			@(posedge clk_sys);
			fill_valid <= 1'b1;
			fill_index <= 7'(i);
			fill_data <= b + 8'(i);
		end
		@(posedge clk_sys);
		fill_valid <= 1'b0;
	endtask
	task automatic run(op_e op, logic [16:0] a, logic [6:0] c);
		int n;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= '{op, a, c};
		@(posedge clk_sys);
		req_valid <= 1'b0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (done !== 1'b1 && n < 20000);
		chk("done", 8'h1, {7'h0, done});
		chk("timeout", 8'h0, {7'h0, timeout});
	endtask
	task automatic rd(logic [16:0] a, logic [7:0] e);
		run(OP_READ, a, 7'h0);
		chk("rd_data", e, rd_data);
	endtask
	task automatic t_page();
		fill(8'h30, 128);
		run(OP_WRITE, 17'h12340, 7'h7f);
		for (int i = 0; i < 128; i++)
			rd(17'h12300 + 17'((i + 64) % 128), 8'h30 + 8'(i));
		$display("page test end");
	endtask
	task automatic t_lock();
		fill(8'h90, 1);
		run(OP_LOCK, 17'h00200, 7'h0);
		chk("locked", 8'h1, {7'h0, locked});
		rd(17'h00200, 8'h90);
		rd(17'h05555, 8'hff);
		fill(8'h11, 1);
		run(OP_WRITE, 17'h00200, 7'h0);
		rd(17'h00200, 8'h90);
		$display("lock test end");
	endtask
	task automatic t_unlock();
		fill(8'h22, 1);
		run(OP_UNLOCK, 17'h00201, 7'h0);
		chk("locked", 8'h0, {7'h0, locked});
		rd(17'h00201, 8'h22);
		$display("unlock test end");
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_page();
		t_lock();
		t_unlock();
		final_report();
	end
endmodule
`default_nettype wire
